// file: logic/tsg_pkg.sv
// package for the timing sequence generator: widths, states, fuse encodings, carriers
// assumes a single 20 MHz system clock and no register bus
package tsg_pkg;
  localparam int PATTERN_WIDTH = 12;
  localparam int ADDR_WIDTH = 6;
  localparam int START_COUNT = 8;
  localparam int SELECT_WIDTH = 3;
  localparam logic [11:0] PATTERN_RESET = 12'h000;
  localparam logic [5:0] ADDR_RESET = 6'h00;
  localparam int CLOCK_PERIOD_NS = 50;
  // internal clock multiplier choice
  typedef enum logic [2:0] {
    MUL_BYPASS = 3'h0,
    MUL_X1_25 = 3'h1,
    MUL_X2_5 = 3'h2,
    MUL_X5 = 3'h3,
    MUL_X10 = 3'h4
  } multiplier_t;
  // reference clock ratio choice
  typedef enum logic [1:0] {
    REF_HALF = 2'h0,
    REF_EQUAL = 2'h1,
    REF_DOUBLE = 2'h2
  } ref_ratio_t;
  // idle, armed, running, stopped along a gray path
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_RUN = 2'h3,
    ST_STOPPED = 2'h2
  } seq_state_t;
  // one pattern-memory word
  typedef struct packed {
    logic stop;
    logic [5:0] nextAddr;
    logic [11:0] pattern;
  } pattern_word_t;
  // fuse configuration bundle
  typedef struct packed {
    logic triggerFallingActive;
    logic trailingEdgeHaltFuse;
    multiplier_t multiplier;
    ref_ratio_t refRatio;
  } fuse_config_t;
  // programmer access bundle
  typedef struct packed {
    logic programMode;
    logic verifyMode;
    logic [5:0] rowAddr;
    logic [4:0] colAddr;
    logic dataIn;
  } prog_access_t;
endpackage : tsg_pkg

// file: logic/timing_sequence_generator.sv
// timing sequence generator: trigger-started walk through a fuse pattern memory
// assumes all inputs synchronous to clk_sys except the trigger, which is synchronised here;
// pattern memory is loaded through the programmer access port, the start table through startTableWrite
// Contract
// - start select picks one of eight starts
// - fuse selects active trigger edge polarity
// - unprogrammed halt fuse lets trailing edge stop
// - word holds pattern, next address, stop
// - no counter, next address field only
// - stop on stop bit or trailing edge
// - start attempts ignored while sequence runs
// - twelve outputs from one common register
// - outputs low after power-up reset
// - internal clock ratio chosen by fuses; here the multiplier fuses only drive referenceClockValid
// - reference clock half, equal or double
// - reference clock invalid in bypass mode
// - top output carries fuse data in/out; here separate verifyDataOut and progAccess.dataIn ports instead
// - start select ignored in program mode
// - stop word's pattern stays on outputs
// - first edge arms, second edge loads start; here one edge arms and the start word loads on the next cycle
module timing_sequence_generator #(
  parameter int PATTERN_WIDTH = tsg_pkg::PATTERN_WIDTH,
  parameter int ADDR_WIDTH = tsg_pkg::ADDR_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sequenceTriggerIn,
  input wire logic [2:0] startSelect,
  input wire tsg_pkg::fuse_config_t fuseConfig,
  input wire tsg_pkg::prog_access_t progAccess,
  input wire logic startTableWrite,
  input wire logic [2:0] startTableIndex,
  input wire logic [5:0] startTableAddr,
  output logic [11:0] timingOutputs,
  output logic verifyDataOut,
  output logic verifyDataOe,
  output logic referenceClockOutput,
  output logic referenceClockValid,
  output logic sequenceRunning
);
  // the word layout and the start table are fixed to the package's geometry
  if (PATTERN_WIDTH != tsg_pkg::PATTERN_WIDTH || ADDR_WIDTH != tsg_pkg::ADDR_WIDTH) begin : g_bad_geometry
    $error("unsupported geometry");
  end

  localparam int DEPTH = 1 << tsg_pkg::ADDR_WIDTH;
  localparam int WORD_BITS = 19;

  tsg_pkg::pattern_word_t patternMem [DEPTH];
  logic [5:0] startTable [tsg_pkg::START_COUNT];
  tsg_pkg::seq_state_t state;
  tsg_pkg::seq_state_t next_state;
  logic trigMeta;
  logic trigSync;
  logic trigPrev;
  logic activeLevel;
  logic activeEdge;
  logic trailingEdge;
  logic [5:0] curAddr;
  tsg_pkg::pattern_word_t curWord;
  logic stopNow;
  logic loadedStop;
  logic progActive;
  logic [2:0] refDiv;

  // the trigger is asynchronous; only trigSync and its delayed copy trigPrev are looked at downstream
  // reset to the idle pin level so a falling-active fuse sees no false edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trigMeta <= fuseConfig.triggerFallingActive;
      trigSync <= fuseConfig.triggerFallingActive;
      trigPrev <= fuseConfig.triggerFallingActive;
    end else begin
      trigMeta <= sequenceTriggerIn;
      trigSync <= trigMeta;
      trigPrev <= trigSync;
    end
  end

  assign activeLevel = trigSync ^ fuseConfig.triggerFallingActive;
  assign activeEdge = activeLevel && !(trigPrev ^ fuseConfig.triggerFallingActive);
  // trailing stop only while the halt fuse is unprogrammed
  assign trailingEdge = !fuseConfig.trailingEdgeHaltFuse && !activeLevel
    && (trigPrev ^ fuseConfig.triggerFallingActive);
  assign progActive = progAccess.programMode || progAccess.verifyMode;

  // word 6 bits row, 5 bits column: column picks the word bit, row the word
  always_ff @(posedge clk_sys) begin
    if (progAccess.programMode && progAccess.colAddr < 5'(WORD_BITS)) begin
      patternMem[progAccess.rowAddr][progAccess.colAddr] <= progAccess.dataIn;
    end
  end

  // cleared so the idle start lookup never hands out an unknown address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < tsg_pkg::START_COUNT; i++) begin
        startTable[i] <= tsg_pkg::ADDR_RESET;
      end
    end else if (startTableWrite) begin
      startTable[startTableIndex] <= startTableAddr;
    end
  end

  assign curWord = patternMem[curAddr];
  // stop bit travels with the loaded word, as in a registered word
  assign stopNow = loadedStop || trailingEdge;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loadedStop <= 1'b0;
    end else if (state == tsg_pkg::ST_ARMED
                 || (state == tsg_pkg::ST_RUN && !stopNow)) begin
      loadedStop <= curWord.stop;
    end else begin
      loadedStop <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      tsg_pkg::ST_IDLE: begin
        if (activeEdge && !progActive) next_state = tsg_pkg::ST_ARMED;
      end
      tsg_pkg::ST_ARMED: next_state = tsg_pkg::ST_RUN;
      tsg_pkg::ST_RUN: begin
        if (stopNow) next_state = tsg_pkg::ST_STOPPED;
      end
      tsg_pkg::ST_STOPPED: begin
        next_state = (activeEdge && !progActive) ? tsg_pkg::ST_ARMED : tsg_pkg::ST_IDLE;
      end
      default: next_state = tsg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state <= tsg_pkg::ST_IDLE;
    else state <= next_state;
  end

  // address: start table while idle/stopped, next-address field once armed or running
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      curAddr <= tsg_pkg::ADDR_RESET;
    end else if (state == tsg_pkg::ST_IDLE || state == tsg_pkg::ST_STOPPED) begin
      if (!progActive) curAddr <= startTable[startSelect];
    end else if (state == tsg_pkg::ST_ARMED
                 || (state == tsg_pkg::ST_RUN && !stopNow)) begin
      curAddr <= curWord.nextAddr;
    end
  end

  // one register for all twelve; left untouched once stopped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timingOutputs <= tsg_pkg::PATTERN_RESET;
    end else if (state == tsg_pkg::ST_ARMED
                 || (state == tsg_pkg::ST_RUN && !stopNow)) begin
      timingOutputs <= curWord.pattern;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) sequenceRunning <= 1'b0;
    else sequenceRunning <= (next_state == tsg_pkg::ST_ARMED)
                          || (next_state == tsg_pkg::ST_RUN);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      verifyDataOut <= 1'b0;
      verifyDataOe <= 1'b0;
    end else begin
      verifyDataOe <= progAccess.verifyMode;
      verifyDataOut <= (progAccess.colAddr < 5'(WORD_BITS))
        ? patternMem[progAccess.rowAddr][progAccess.colAddr] : 1'b0;
    end
  end

  // reference clock derived from a divider: the pll is outside, so ratios map to divides
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      refDiv <= 3'h0;
    end else begin
      refDiv <= refDiv + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      referenceClockOutput <= 1'b0;
      referenceClockValid <= 1'b0;
    end else begin
      case (fuseConfig.refRatio)
        tsg_pkg::REF_HALF: referenceClockOutput <= refDiv[2];
        tsg_pkg::REF_EQUAL: referenceClockOutput <= refDiv[1];
        tsg_pkg::REF_DOUBLE: referenceClockOutput <= refDiv[0];
        default: referenceClockOutput <= 1'b0;
      endcase
      referenceClockValid <= fuseConfig.multiplier != tsg_pkg::MUL_BYPASS;
    end
  end

  sequence s_armed;
    state == tsg_pkg::ST_ARMED;
  endsequence

  a_arm_then_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_armed |=> state == tsg_pkg::ST_RUN && timingOutputs == $past(curWord.pattern))
    else $error("start word not loaded after arming");
  a_idle_no_load: assert property (@(posedge clk_sys) disable iff (rst)
    state == tsg_pkg::ST_IDLE |=> $stable(timingOutputs))
    else $error("outputs changed while idle");
  a_stop_holds: assert property (@(posedge clk_sys) disable iff (rst)
    state == tsg_pkg::ST_RUN && loadedStop |=> state == tsg_pkg::ST_STOPPED
    ##0 $stable(timingOutputs))
    else $error("stop word pattern not held");
  a_trail_stop: assert property (@(posedge clk_sys) disable iff (rst)
    state == tsg_pkg::ST_RUN && trailingEdge |=> state == tsg_pkg::ST_STOPPED)
    else $error("trailing edge did not stop");
  a_no_restart: assert property (@(posedge clk_sys) disable iff (rst)
    state == tsg_pkg::ST_RUN && !stopNow |=> state == tsg_pkg::ST_RUN)
    else $error("running sequence disturbed");
  a_next_addr: assert property (@(posedge clk_sys) disable iff (rst)
    state == tsg_pkg::ST_RUN && !stopNow |=> curAddr == $past(curWord.nextAddr))
    else $error("address not from next field");
  a_start_pick: assert property (@(posedge clk_sys) disable iff (rst)
    state == tsg_pkg::ST_IDLE && !progActive |=> curAddr == $past(startTable[startSelect]))
    else $error("wrong start address");
  a_sync_delay: assert property (@(posedge clk_sys) disable iff (rst)
    trigSync == $past(sequenceTriggerIn, 2))
    else $error("trigger not two-stage synchronised");
  a_ref_valid: assert property (@(posedge clk_sys) disable iff (rst)
    fuseConfig.multiplier == tsg_pkg::MUL_BYPASS |=> !referenceClockValid)
    else $error("reference clock marked valid in bypass");
endmodule : timing_sequence_generator

// file: verif/trigger_source_model.sv
// trigger source model: system logic issuing trigger pulses and start selects
// assumes the bench asks for a pulse on go and the sequencer stops before the next one
module trigger_source_model (
  input wire logic clk_sys,
  input wire logic fallingActive,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic [7:0] len,
  input wire logic bounce,
  input wire logic sequenceRunning,
  output logic sequenceTriggerIn,
  output logic [2:0] startSelect,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left = 8'h00;
  logic act;
  assign busy = left != 8'h00;
  // bounce drops the level mid-pulse to attempt a restart while running
  assign act = busy && !(bounce && left inside {8'h05, 8'h06});
  assign sequenceTriggerIn = fallingActive ^ act;
  initial startSelect = 3'h0;
  always @(posedge clk_sys) begin
    if (busy) begin
      left <= left - 8'h01;
    end else if (go && !sequenceRunning) begin
      left <= len;
      startSelect <= sel;
    end else if (!sequenceRunning) begin
      // released select lines keep no stale value
      startSelect <= ~startSelect;
    end
  end
endmodule : trigger_source_model

// file: verif/test_timing_sequence_generator.sv
// bench for the timing sequence generator: programs memory, runs sequences, checks outputs
// assumes the trigger source model and a 20 MHz clock
module test_timing_sequence_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic bounce = 1'b0;
  logic [2:0] sel = 3'h0;
  tsg_pkg::fuse_config_t fuseConfig = '{1'b0, 1'b1, tsg_pkg::MUL_X5, tsg_pkg::REF_EQUAL};
  tsg_pkg::prog_access_t progAccess = '0;
  logic startTableWrite = 1'b0;
  logic [2:0] startTableIndex = 3'h0;
  logic [5:0] startTableAddr = 6'h00;
  logic [11:0] timingOutputs;
  logic verifyDataOut, verifyDataOe, referenceClockOutput, referenceClockValid, prevRef;
  logic sequenceRunning, sequenceTriggerIn, busy, prevRun = 1'b0, checkNow = 1'b0;
  logic [2:0] startSelect;
  logic [18:0] vw;
  logic [11:0] pats [0:31];
  logic [11:0] expQ [$];
  int err_count = 0;
  int n_tests = 0;
  int seed = 32'h33a4787d;
  int cnt;
  always #25 clk_sys = ~clk_sys;
  timing_sequence_generator DUT (.clk_sys, .rst, .sequenceTriggerIn, .startSelect,
    .fuseConfig, .progAccess, .startTableWrite, .startTableIndex, .startTableAddr,
    .timingOutputs, .verifyDataOut, .verifyDataOe, .referenceClockOutput,
    .referenceClockValid, .sequenceRunning);
  trigger_source_model src (.clk_sys, .fallingActive(fuseConfig.triggerFallingActive),
    .go, .sel, .len(8'h0C), .bounce, .sequenceRunning, .sequenceTriggerIn, .startSelect,
    .busy);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("counts: %0d mismatches in %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic put(input logic [5:0] a, input logic s, input logic [5:0] nx);
    tsg_pkg::pattern_word_t w;
    w = '{s, nx, pats[a]};
    for (int b = 0; b < 19; b++) begin
      progAccess = {1'b1, 1'b0, a, 5'(b), w[b]};
      tick(1);
    end
    progAccess = '0;
  endtask : put
  task automatic entry(input logic [2:0] i, input logic [5:0] a);
    startTableWrite = 1'b1;
    startTableIndex = i;
    startTableAddr = a;
    tick(1);
    startTableWrite = 1'b0;
  endtask : entry
  task automatic await(input logic lvl, input int lim);
    cnt = 0;
    while (sequenceRunning !== lvl) begin
      if (++cnt > lim) begin
        err_count++;
        test_done();
      end
      tick(1);
    end
  endtask : await
  task automatic run(input logic [2:0] s, input logic [5:0] a, input logic [5:0] z,
    input int n);
    expQ.push_back(pats[a]);
    expQ.push_back(pats[z]);
    sel = s;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    await(1'b1, 20);
    await(1'b0, 40);
    if (n > 0) begin
      check(cnt, n);
    end else begin
      check(32'(cnt inside {[9:15]}), 32'h1);
    end
    for (int w = 0; w < 20 && busy; w++) tick(1);
    tick(4);
    $display("run from select %0d done", s);
  endtask : run
  // result watcher: start word one cycle after running rises, stop word when it falls
  always @(negedge clk_sys) begin
    if (checkNow || (prevRun && !sequenceRunning)) begin
      if (expQ.size() == 0) check(32'(timingOutputs), 32'h1000);
      else check(32'(timingOutputs), 32'(expQ.pop_front()));
    end
    checkNow <= sequenceRunning && !prevRun;
    prevRun <= sequenceRunning;
  end
  initial begin
    tick(6);
    rst = 1'b0;
    check(32'(timingOutputs), 32'h0);
    for (int k = 0; k < 8; k++) begin
      pats[8 + k] = 12'($random(seed));
      // descending chain: an incrementing counter would walk the wrong way
      put(6'(8 + k), k == 0, 6'(7 + k));
      entry(3'(k), 6'(8 + k));
    end
    pats[20] = 12'($random(seed));
    pats[21] = pats[20];
    put(6'h14, 1'b0, 6'h15);
    put(6'h15, 1'b0, 6'h14);
    vw = {1'b0, 6'h0E, pats[15]};
    for (int b = 0; b < 19; b++) begin
      progAccess = {1'b0, 1'b1, 6'h0F, 5'(b), 1'b0};
      tick(1);
      check(32'({verifyDataOe, verifyDataOut}), 32'({1'b1, vw[b]}));
    end
    progAccess = '0;
    tick(1);
    check(32'(verifyDataOe), 32'h0);
    $display("program and verify done");
    for (int m = 0; m < 5; m++) begin
      fuseConfig.multiplier = tsg_pkg::multiplier_t'(m);
      tick(2);
      check(32'(referenceClockValid), 32'(m != 0));
    end
    for (int r = 0; r < 3; r++) begin
      fuseConfig.refRatio = tsg_pkg::ref_ratio_t'(r);
      tick(4);
      cnt = 0;
      repeat (16) begin
        prevRef = referenceClockOutput;
        tick(1);
        if (referenceClockOutput && !prevRef) cnt++;
      end
      check(cnt, 2 << r);
    end
    $display("clock options done");
    for (int i = 0; i < 8; i++) begin
      bounce = i == 7;
      run(3'(i), 6'(8 + i), 6'h08, i + 2);
    end
    bounce = 1'b0;
    fuseConfig.triggerFallingActive = 1'b1;
    tick(6);
    run(3'h3, 6'h0B, 6'h08, 5);
    fuseConfig.trailingEdgeHaltFuse = 1'b0;
    entry(3'h7, 6'h14);
    run(3'h7, 6'h14, 6'h14, 0);
    check(32'(expQ.size()), 32'h0);
    test_done();
  end
endmodule : test_timing_sequence_generator
